// >>> bench/pgh_pad_model.sv
// Purpose: Pad model that resolves each pin from every party that can drive it.
// Assumes: The block's driver wins, then an external source, then the pull-up.
// Notes:   A pin nobody holds shows the inverse of its last level.
`timescale 1ns/10ps
`default_nettype none
module pgh_pad_model (
  // Clock.
  input  wire logic        clk_in,
  // Block side.
  input  wire logic [13:0] oe_in,
  input  wire logic [13:0] out_in,
  input  wire logic [13:0] pullup_in,
  // External sources.
  input  wire logic [13:0] ext_en_in,
  input  wire logic [13:0] ext_val_in,
  // Resolved pins.
  output logic      [13:0] pad_out
);
  logic [13:0] last_reg = 14'h0000;

  // Resolves every pin; a pull-up only sets the level when nothing drives it.
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      if (oe_in[i]) begin
        pad_out[i] = out_in[i];
      end else if (ext_en_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else if (pullup_in[i]) begin
        pad_out[i] = 1'b1;
      end else begin
        pad_out[i] = ~last_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    last_reg <= pad_out;
  end
endmodule : pgh_pad_model
`default_nettype wire

// >>> bench/pgh_pin_override_tb_top.sv
// Purpose: Self-checking bench for the port G/H pin override block.
// Assumes: Inputs change at the falling edge and outputs are read there.
// Notes:   Pad levels come from the pad model.
`timescale 1ns/10ps
`default_nettype none
module pgh_pin_override_tb_top;
  import pgh_pkg::*;
  logic         clk;
  logic         rst;
  pgh_ctrl_t    ctrl;
  logic [7:0]   pcmsk;
  logic         fuse;
  logic [13:0]  val, dir, pad, ext_en, ext_val;
  logic [13:0]  p_out, p_oe, p_pu, p_ie, smp, ana;
  logic         tm0, tm1, rreq;
  logic [23:16] pcs;
  logic [39:0]  fp;
  int           fails, total_checks, cycles;

  pgh_pin_override dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .CTRL_IN(ctrl), .PIN_CHANGE_MASK_IN(pcmsk),
    .RESET_PIN_DISABLE_FUSE_IN(fuse), .PORT_OUT_VAL_IN(val), .PORT_DIR_IN(dir), .PAD_IN(pad),
    .PAD_OUT(p_out), .PAD_OE_OUT(p_oe), .PAD_PULLUP_OUT(p_pu), .PAD_INPUT_EN_OUT(p_ie),
    .SAMPLED_PIN_INPUT_OUT(smp), .TIMER0_COUNT_INPUT_OUT(tm0), .TIMER1_COUNT_INPUT_OUT(tm1),
    .PIN_CHANGE_SOURCE_OUT(pcs), .EXT_RESET_REQ_OUT(rreq), .SEGMENT_ANALOG_DRIVE_OUT(ana),
    .SEGMENT_FRONT_PLANE_OUT(fp));

  pgh_pad_model pads (.clk_in(clk), .oe_in(p_oe), .out_in(p_out), .pullup_in(p_pu),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_out(pad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [39:0] got, input logic [39:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  function automatic logic [13:0] ie_exp(input pgh_ctrl_t c);
    logic [13:0] r;
    r = 14'h3fff;
    if (c.lcd_enable_bit) r[2] = 1'b0;
    if (c.lcd_enable_bit & c.lcd_pin_mode_bit) r = r & ~14'h001b;
    return r;
  endfunction : ie_exp

  // Applies control values and judges every control output one cycle later.
  task automatic set_ctrl(input pgh_ctrl_t c, input logic [13:0] v, input logic [13:0] d);
    logic [13:0] pu;
    logic [13:0] oe;
    logic [39:0] f;
    @(negedge clk);
    ctrl = c;
    val = v;
    dir = d;
    pu = v & ~d & {14{~c.pullup_disable_all}};
    oe = d;
    f = 40'h0;
    if (c.lcd_enable_bit) begin
      pu = pu & ~14'h3fdf;
      oe = (oe & ~14'h3fdf) | 14'h0010;
      f = c.pkg_100pin ? 40'hf3_0006_0790 : 40'h00_0180_6010;
    end
    pu[5] = 1'b1;
    oe[5] = 1'b0;
    v[5] = 1'b0;
    @(negedge clk);
    check_val(40'(p_pu), 40'(pu), "pull-up");
    check_val(40'(p_oe), 40'(oe), "direction");
    check_val(40'(p_out), 40'(v), "output value");
    check_val(40'(p_ie), 40'(ie_exp(c)), "input enable");
    check_val(40'(ana), c.lcd_enable_bit ? 40'h3fdf : 40'h0, "analog path");
    check_val(fp, f, "front planes");
  endtask : set_ctrl

  task automatic t_reset();
    repeat (8) @(negedge clk);
    check_val(40'(p_pu), 40'h0, "pull-up in reset");
    check_val(40'(smp), 40'h0, "sampled in reset");
    rst = 1'b0;
  endtask : t_reset

  task automatic t_normal();
    set_ctrl(5'b00000, 14'h3fff, 14'h0f0f);
    set_ctrl(5'b00010, 14'h3fff, 14'h30f0);
    set_ctrl(5'b00000, 14'h1234, 14'h0421);
  endtask : t_normal

  task automatic t_lcd();
    for (int i = 0; i < 8; i++) begin
      set_ctrl({1'b1, i[2], i[1], 1'b0, i[0]}, 14'h2aaa, 14'h1555);
    end
  endtask : t_lcd

  // Drives the pads from outside and judges the sampled paths three edges later.
  task automatic t_pads(input pgh_ctrl_t c, input logic [13:0] pat);
    logic [13:0] e;
    set_ctrl(c, 14'h0000, 14'h0000);
    ext_en = 14'h3fdf;
    ext_val = pat;
    repeat (3) @(negedge clk);
    e = {pat[13:6], 1'b1, pat[4:0]} & ie_exp(c);
    check_val(40'(smp), 40'(e), "sampled inputs");
    check_val(40'(tm0), 40'(e[4]), "timer0 count");
    check_val(40'(tm1), 40'(e[3]), "timer1 count");
    check_val(40'(pcs), 40'(e[13:6]), "pin change");
    check_val(40'(rreq), 40'h0, "reset request");
  endtask : t_pads

  task automatic t_fuse();
    @(negedge clk);
    ext_en = 14'h0020;
    ext_val = 14'h0000;
    fuse = 1'b1;
    repeat (3) @(negedge clk);
    check_val(40'(rreq), 40'h1, "reset active");
    fuse = 1'b0;
    repeat (3) @(negedge clk);
    check_val(40'(rreq), 40'h0, "reset removed");
    check_val(40'(smp[5]), 40'h0, "bit5 low");
    ext_en = 14'h0000;
    repeat (3) @(negedge clk);
    check_val(40'(smp[5]), 40'h1, "bit5 pulled up");
    check_val(40'(p_oe[5]), 40'h0, "bit5 driver");
  endtask : t_fuse

  initial begin
    rst = 1'b1;
    ctrl = '0;
    pcmsk = 8'hff;
    fuse = 1'b1;
    val = 14'h0000;
    dir = 14'h0000;
    ext_en = 14'h0000;
    ext_val = 14'h0000;
    fails = 0;
    total_checks = 0;
    t_reset();
    t_normal();
    t_lcd();
    t_pads(5'b00000, 14'h2a5a);
    t_pads(5'b00000, 14'h15a5);
    t_pads(5'b11101, 14'h3fff);
    t_fuse();
    complete_run();
  end
endmodule : pgh_pin_override_tb_top
`default_nettype wire

// >>> core/pgh_pin_override.sv
// Purpose: Pin override logic for port G and port H alternate functions.
// Assumes: Port registers, LCD enable and interrupt masks come from CLOCK_IN logic.
// Notes:   Pad inputs and the fuse strap are synchronised; every output is registered.
//
// Function
// R01: Port G bit 5 is input only; driver never enabled, pull-up always on; the code holds its pull-up off while SYS_RST_IN is high.
// R02: Fuse programmed low removes external reset; bit 5 becomes pulled-up general input.
// R03: G4 with LCD enabled: pull-up off, direction 1, output value untouched, segment path.
// R04: G3..G0 with LCD enabled: pull-up off, direction 0, segment path, output untouched.
// R05: G4,G3,G1,G0 input buffer off on LCD enable and pin mode; G2 on enable.
// R06: Synchronised G4 input feeds timer 0 external count input.
// R07: Synchronised G3 input feeds timer 1 external count input.
// R08: G segment pins map to package-dependent front planes 32/23,33/24,4/4,17/13,18/14.
// R09: Port H bits 7..0 are pin-change sources 23..16 via their digital inputs.
// R10: Port H with LCD enabled: pull-up off, direction 0, segment path, output untouched.
// R11: Port H input override enable is mask AND group0 enable AND LCD enable AND mode.
// R12: H7..H4 drive front planes 36..39, H3..H0 drive front planes 7..10; the code drives them only with pkg_100pin set.
// R13: An asserted override enable replaces the register setting with its override value.
`timescale 1ns/10ps
`default_nettype none
module pgh_pin_override (
  // Clock and reset.
  input  wire logic                  CLOCK_IN,
  input  wire logic                  SYS_RST_IN,
  // Control bits.
  input  wire pgh_pkg::pgh_ctrl_t    CTRL_IN,
  input  wire logic [7:0]            PIN_CHANGE_MASK_IN,
  input  wire logic                  RESET_PIN_DISABLE_FUSE_IN,
  // Port registers.
  input  wire logic [13:0]           PORT_OUT_VAL_IN,
  input  wire logic [13:0]           PORT_DIR_IN,
  // Pads.
  input  wire logic [13:0]           PAD_IN,
  output logic      [13:0]           PAD_OUT,
  output logic      [13:0]           PAD_OE_OUT,
  output logic      [13:0]           PAD_PULLUP_OUT,
  output logic      [13:0]           PAD_INPUT_EN_OUT,
  // Alternate function outputs.
  output logic      [13:0]           SAMPLED_PIN_INPUT_OUT,
  output logic                       TIMER0_COUNT_INPUT_OUT,
  output logic                       TIMER1_COUNT_INPUT_OUT,
  output logic      [23:16]          PIN_CHANGE_SOURCE_OUT,
  output logic                       EXT_RESET_REQ_OUT,
  output logic      [13:0]           SEGMENT_ANALOG_DRIVE_OUT,
  output logic      [39:0]           SEGMENT_FRONT_PLANE_OUT
);
  import pgh_pkg::*;

  pgh_ovr_t          ovr [PGH_NPIN];
  logic [13:0]       pad_sync;
  logic              fuse_sync;
  logic [13:0]       pull_next;
  logic [13:0]       oe_next;
  logic [13:0]       out_next;
  logic [13:0]       ie_next;
  logic [13:0]       sampled_next;
  logic [13:0]       analog_next;
  logic [39:0]       fp_next;
  logic              rstreq_next;
  logic              lcd_en;
  logic              lcd_pm;

  assign lcd_en = CTRL_IN.lcd_enable_bit;
  assign lcd_pm = CTRL_IN.lcd_pin_mode_bit;

  // Pad levels and the fuse strap cross into the clock domain.
  pgh_sync #(
    .WIDTH (PGH_NPIN + 1)
  ) u_sync (
    .clk_in (CLOCK_IN),
    .rst_in (SYS_RST_IN),
    .d_in   ({RESET_PIN_DISABLE_FUSE_IN, PAD_IN}),
    .q_out  ({fuse_sync, pad_sync})
  );

  // Override enables and values per pin.
  for (genvar i = 0; i < PGH_NPIN; i++) begin : g_ovr
    if (i == PGH_RST_BIT) begin : g_rst
      assign ovr[i].pullup_override_enable       = 1'b1;  // [R01] [R02]
      assign ovr[i].pullup_override_value        = 1'b1;  // [R01] [R02]
      assign ovr[i].direction_override_enable    = 1'b1;  // [R01]
      assign ovr[i].direction_override_value     = 1'b0;  // [R01]
      assign ovr[i].output_value_override_enable = 1'b1;  // [R01]
      assign ovr[i].output_value_override_value  = 1'b0;  // [R01]
      assign ovr[i].input_buffer_override_enable = 1'b0;  // [R02]
      assign ovr[i].input_buffer_override_value  = 1'b1;
    end else if (i >= PGH_H_BASE) begin : g_h
      assign ovr[i].pullup_override_enable       = lcd_en;  // [R10]
      assign ovr[i].pullup_override_value        = 1'b0;    // [R10]
      assign ovr[i].direction_override_enable    = lcd_en;  // [R10]
      assign ovr[i].direction_override_value     = 1'b0;    // [R10]
      assign ovr[i].output_value_override_enable = 1'b0;    // [R10]
      assign ovr[i].output_value_override_value  = 1'b0;
      assign ovr[i].input_buffer_override_enable = PIN_CHANGE_MASK_IN[i-PGH_H_BASE]
                                                   & CTRL_IN.pin_change_group0_enable
                                                   & lcd_en & lcd_pm;  // [R11]
      assign ovr[i].input_buffer_override_value  = 1'b1;
    end else begin : g_g
      assign ovr[i].pullup_override_enable       = lcd_en;  // [R03] [R04]
      assign ovr[i].pullup_override_value        = 1'b0;    // [R03] [R04]
      assign ovr[i].direction_override_enable    = lcd_en;  // [R03] [R04]
      assign ovr[i].direction_override_value     = PGH_DIRECTION_OVERRIDE_VALUE_ONE_PINS[i];  // [R03] [R04]
      assign ovr[i].output_value_override_enable = 1'b0;    // [R03] [R04]
      assign ovr[i].output_value_override_value  = 1'b0;
      assign ovr[i].input_buffer_override_enable = PGH_DIE_LCD_ONLY[i] ? lcd_en
                                                                       : (lcd_en & lcd_pm);  // [R05]
      assign ovr[i].input_buffer_override_value  = 1'b0;    // [R05]
    end
  end

  // Final pad controls: override value where enabled, otherwise the register setting, or 1 for the input enable.
  always_comb begin
    for (int i = 0; i < PGH_NPIN; i++) begin
      pull_next[i] = ovr[i].pullup_override_enable ? ovr[i].pullup_override_value
                   : (PORT_OUT_VAL_IN[i] & ~PORT_DIR_IN[i] & ~CTRL_IN.pullup_disable_all);  // [R13]
      oe_next[i]   = ovr[i].direction_override_enable ? ovr[i].direction_override_value
                   : PORT_DIR_IN[i];  // [R13]
      out_next[i]  = ovr[i].output_value_override_enable ? ovr[i].output_value_override_value
                   : PORT_OUT_VAL_IN[i];  // [R13]
      ie_next[i]   = ovr[i].input_buffer_override_enable ? ovr[i].input_buffer_override_value
                   : 1'b1;  // [R13]
      sampled_next[i] = pad_sync[i] & ie_next[i];
      analog_next[i]  = PGH_SEG_PINS[i] & lcd_en;  // [R03] [R04] [R10]
    end
  end

  // Front plane lines driven by pins in segment use.
  always_comb begin
    fp_next = PGH_FP_RST;
    for (int i = 0; i < PGH_NPIN; i++) begin
      if (PGH_SEG_PINS[i] && lcd_en && (!PGH_H_PINS[i] || CTRL_IN.pkg_100pin)) begin
        if (CTRL_IN.pkg_100pin) begin
          fp_next[PGH_FP_100[i]] = 1'b1;  // [R08] [R12]
        end else begin
          fp_next[PGH_FP_64[i]] = 1'b1;  // [R08]
        end
      end
    end
  end

  // External reset stays live only while the fuse is unprogrammed.
  assign rstreq_next = (fuse_sync != PGH_FUSE_PROGRAMMED) & ~pad_sync[PGH_RST_BIT];  // [R02]

  // Pad control registers.
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      PAD_OUT          <= PGH_PIN_RST;
      PAD_OE_OUT       <= PGH_PIN_RST;
      PAD_PULLUP_OUT   <= PGH_PIN_RST;
      PAD_INPUT_EN_OUT <= PGH_PIN_RST;
    end else begin
      PAD_OUT          <= out_next;
      PAD_OE_OUT       <= oe_next;   // [R01]
      PAD_PULLUP_OUT   <= pull_next; // [R01]
      PAD_INPUT_EN_OUT <= ie_next;
    end
  end

  // Digital inputs and their alternate consumers.
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      SAMPLED_PIN_INPUT_OUT  <= PGH_PIN_RST;
      TIMER0_COUNT_INPUT_OUT <= 1'b0;
      TIMER1_COUNT_INPUT_OUT <= 1'b0;
      PIN_CHANGE_SOURCE_OUT  <= '0;
    end else begin
      SAMPLED_PIN_INPUT_OUT  <= sampled_next;
      TIMER0_COUNT_INPUT_OUT <= sampled_next[PGH_T0_BIT];  // [R06]
      TIMER1_COUNT_INPUT_OUT <= sampled_next[PGH_T1_BIT];  // [R07]
      PIN_CHANGE_SOURCE_OUT  <= sampled_next[PGH_NPIN-1:PGH_H_BASE];  // [R09]
    end
  end

  // Segment and reset outputs.
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      SEGMENT_ANALOG_DRIVE_OUT <= PGH_PIN_RST;
      SEGMENT_FRONT_PLANE_OUT  <= PGH_FP_RST;
      EXT_RESET_REQ_OUT        <= PGH_RSTREQ_RST;
    end else begin
      SEGMENT_ANALOG_DRIVE_OUT <= analog_next;
      SEGMENT_FRONT_PLANE_OUT  <= fp_next;
      EXT_RESET_REQ_OUT        <= rstreq_next;
    end
  end

  // Checks on the registered outputs.
  a_g5_input_only: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R01]
    !$past(SYS_RST_IN) |-> (!PAD_OE_OUT[5] && PAD_PULLUP_OUT[5] && !PAD_OUT[5]))
    else $error("Port G bit 5 driven or pull-up off.");

  a_fuse_reset_gone: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R02]
    (!RESET_PIN_DISABLE_FUSE_IN [*4]) |-> !EXT_RESET_REQ_OUT)
    else $error("Reset request raised with the fuse programmed.");

  a_g4_lcd_force: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R03]
    (!$past(SYS_RST_IN) && $past(lcd_en)) |->
      (!PAD_PULLUP_OUT[4] && PAD_OE_OUT[4] && PAD_OUT[4] == $past(PORT_OUT_VAL_IN[4])
       && SEGMENT_ANALOG_DRIVE_OUT[4]))
    else $error("Port G bit 4 not forced under LCD enable.");

  a_g30_lcd_force: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R04]
    (!$past(SYS_RST_IN) && $past(lcd_en)) |->
      (PAD_PULLUP_OUT[3:0] == 4'h0 && PAD_OE_OUT[3:0] == 4'h0
       && PAD_OUT[3:0] == $past(PORT_OUT_VAL_IN[3:0]) && SEGMENT_ANALOG_DRIVE_OUT[3:0] == 4'hf))
    else $error("Port G bits 3..0 not forced under LCD enable.");

  a_g_inbuf_off: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R05]
    !$past(SYS_RST_IN) |->
      (PAD_INPUT_EN_OUT[2] == !$past(lcd_en)
       && PAD_INPUT_EN_OUT[4] == !$past(lcd_en && lcd_pm)
       && PAD_INPUT_EN_OUT[0] == !$past(lcd_en && lcd_pm)))
    else $error("Port G input buffer override wrong.");

  a_timer_inputs: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R06] [R07]
    (!$past(SYS_RST_IN, 3) && !$past(lcd_en)) |->
      (TIMER0_COUNT_INPUT_OUT == $past(PAD_IN[4], 3) && TIMER1_COUNT_INPUT_OUT == $past(PAD_IN[3], 3)))
    else $error("Timer count input does not follow its pin.");

  a_g_fp_map: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R08]
    (!$past(SYS_RST_IN) && $past(lcd_en)) |->
      ($past(CTRL_IN.pkg_100pin) ? (SEGMENT_FRONT_PLANE_OUT[32] && SEGMENT_FRONT_PLANE_OUT[33]
                                   && SEGMENT_FRONT_PLANE_OUT[17] && SEGMENT_FRONT_PLANE_OUT[18])
                                 : (SEGMENT_FRONT_PLANE_OUT[23] && SEGMENT_FRONT_PLANE_OUT[24]
                                   && SEGMENT_FRONT_PLANE_OUT[13] && SEGMENT_FRONT_PLANE_OUT[14]))
      && SEGMENT_FRONT_PLANE_OUT[4])
    else $error("Port G front plane map wrong.");

  a_pcint_route: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R09]
    PIN_CHANGE_SOURCE_OUT == SAMPLED_PIN_INPUT_OUT[13:6])
    else $error("Pin change sources do not match port H inputs.");

  a_h_lcd_force: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R10]
    (!$past(SYS_RST_IN) && $past(lcd_en)) |->
      (PAD_PULLUP_OUT[13:6] == 8'h00 && PAD_OE_OUT[13:6] == 8'h00
       && PAD_OUT[13:6] == $past(PORT_OUT_VAL_IN[13:6])))
    else $error("Port H not forced under LCD enable.");

  a_h_inbuf_and: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R11]
    (!$past(SYS_RST_IN) && !$past(CTRL_IN.pin_change_group0_enable)) |-> PAD_INPUT_EN_OUT[13:6] == 8'hff)
    else $error("Port H input override without group enable.");

  a_h_fp_map: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R12]
    (!$past(SYS_RST_IN) && $past(lcd_en && CTRL_IN.pkg_100pin)) |->
      (SEGMENT_FRONT_PLANE_OUT[39:36] == 4'hf && SEGMENT_FRONT_PLANE_OUT[10:7] == 4'hf))
    else $error("Port H front plane map wrong.");

  a_reg_select: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R13]
    (!$past(SYS_RST_IN) && !$past(lcd_en)) |->
      (PAD_OE_OUT[13:6] == $past(PORT_DIR_IN[13:6]) && PAD_OE_OUT[4:0] == $past(PORT_DIR_IN[4:0])))
    else $error("Direction register not used without override.");

  a_pcint_pads: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R09]
    (!$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) && !$past(SYS_RST_IN, 3)) |->
      PIN_CHANGE_SOURCE_OUT == $past(PAD_IN[13:6], 3))
    else $error("Pin change source does not follow its port H pad.");

  a_g5_sampled: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R02]
    (!$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) && !$past(SYS_RST_IN, 3)) |->
      SAMPLED_PIN_INPUT_OUT[5] == $past(PAD_IN[5], 3))
    else $error("Port G bit 5 input does not follow its pad.");

  a_reset_req_pin: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R02]
    (!$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) && !$past(SYS_RST_IN, 3)) |->
      EXT_RESET_REQ_OUT == ($past(RESET_PIN_DISABLE_FUSE_IN, 3) && !$past(PAD_IN[5], 3)))
    else $error("Reset request does not follow fuse and pin.");

  a_fuse_reset_live: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R02]
    (RESET_PIN_DISABLE_FUSE_IN && !PAD_IN[5]) [*4] |-> EXT_RESET_REQ_OUT)
    else $error("Reset request missing with the fuse unprogrammed and pin low.");

  a_g5_buffer_on: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R01] [R02]
    !$past(SYS_RST_IN) |-> (PAD_INPUT_EN_OUT[5] && !SEGMENT_ANALOG_DRIVE_OUT[5]))
    else $error("Port G bit 5 input buffer off or segment path on.");

  a_g_inbuf_mid: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R05]
    !$past(SYS_RST_IN) |->
      (PAD_INPUT_EN_OUT[1] == !$past(lcd_en && lcd_pm) && PAD_INPUT_EN_OUT[3] == !$past(lcd_en && lcd_pm)))
    else $error("Port G bits 1 or 3 input buffer override wrong.");

  a_timer_gated: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R05] [R06] [R07]
    (!$past(SYS_RST_IN) && $past(lcd_en && lcd_pm)) |-> (!TIMER0_COUNT_INPUT_OUT && !TIMER1_COUNT_INPUT_OUT))
    else $error("Timer count input live with its input buffer off.");

  a_seg_on_map: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R03] [R04] [R10]
    (!$past(SYS_RST_IN) && $past(lcd_en)) |->
      SEGMENT_ANALOG_DRIVE_OUT == 14'h3fdf)
    else $error("Segment analog path not connected under LCD enable.");

  a_seg_idle: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R08] [R12]
    (!$past(SYS_RST_IN) && !$past(lcd_en)) |->
      (SEGMENT_ANALOG_DRIVE_OUT == 14'h0000 && SEGMENT_FRONT_PLANE_OUT == 40'h00_0000_0000))
    else $error("Segment path active without LCD enable.");

  a_h_fp_small: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R12]
    (!$past(SYS_RST_IN) && !$past(CTRL_IN.pkg_100pin)) |->
      (SEGMENT_FRONT_PLANE_OUT[39:36] == 4'h0 && SEGMENT_FRONT_PLANE_OUT[10:7] == 4'h0))
    else $error("Port H front plane driven on the small package.");

  a_out_untouched: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R03] [R04] [R10] [R13]
    !$past(SYS_RST_IN) |->
      (PAD_OUT[4:0] == $past(PORT_OUT_VAL_IN[4:0]) && PAD_OUT[13:6] == $past(PORT_OUT_VAL_IN[13:6])))
    else $error("Port output value overridden.");

  a_pullup_disabled: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [R01] [R13]
    (!$past(SYS_RST_IN) && $past(CTRL_IN.pullup_disable_all)) |->
      (PAD_PULLUP_OUT[4:0] == 5'h00 && PAD_PULLUP_OUT[13:6] == 8'h00 && PAD_PULLUP_OUT[5]))
    else $error("Pull-up left on under global pull-up disable.");

endmodule : pgh_pin_override
`default_nettype wire

// >>> core/pgh_pkg.sv
// Purpose: Shared constants and types for the port G/H pin override block.
// Assumes: Pins 0..5 are port G bits 0..5, pins 6..13 are port H bits 0..7.
// Notes:   Front plane tables hold one entry per pin; unused entries are never read.
package pgh_pkg;

  // Pin layout.
  localparam int PGH_NPIN       = 14;
  localparam int PGH_NG         = 6;
  localparam int PGH_NH         = 8;
  localparam int PGH_H_BASE     = 6;
  localparam int PGH_RST_BIT    = 5;
  localparam int PGH_T0_BIT     = 4;
  localparam int PGH_T1_BIT     = 3;
  localparam int PGH_NFP        = 40;
  localparam int PGH_PCINT_BASE = 16;
  localparam int PGH_PCINT_TOP  = 23;
  localparam int PGH_SYNC_DEPTH = 2;

  // Pin class masks.
  localparam logic [13:0] PGH_SEG_PINS      = 14'h3fdf;
  localparam logic [13:0] PGH_H_PINS        = 14'h3fc0;
  localparam logic [13:0] PGH_DIRECTION_OVERRIDE_VALUE_ONE_PINS = 14'h0010;
  localparam logic [13:0] PGH_DIE_LCD_ONLY  = 14'h0004;

  // Fuse level that means programmed.
  localparam logic PGH_FUSE_PROGRAMMED = 1'b0;

  // Reset values.
  localparam logic [13:0] PGH_PIN_RST   = 14'h0000;
  localparam logic [39:0] PGH_FP_RST    = 40'h00_0000_0000;
  localparam logic        PGH_RSTREQ_RST = 1'b0;

  // Front plane index for each pin, 100-pin and 64-pin packages.
  localparam logic [5:0] PGH_FP_100 [PGH_NPIN] = '{6'h12, 6'h11, 6'h04, 6'h21, 6'h20, 6'h00,
                                                  6'h0a, 6'h09, 6'h08, 6'h07,
                                                  6'h27, 6'h26, 6'h25, 6'h24};
  localparam logic [5:0] PGH_FP_64  [PGH_NPIN] = '{6'h0e, 6'h0d, 6'h04, 6'h18, 6'h17, 6'h00,
                                                  6'h0a, 6'h09, 6'h08, 6'h07,
                                                  6'h27, 6'h26, 6'h25, 6'h24};

  // Control bits from the LCD and interrupt units.
  typedef struct packed {
    logic lcd_enable_bit;
    logic lcd_pin_mode_bit;
    logic pin_change_group0_enable;
    logic pullup_disable_all;
    logic pkg_100pin;
  } pgh_ctrl_t;

  // Override set for one pin.
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic output_value_override_enable;
    logic output_value_override_value;
    logic input_buffer_override_enable;
    logic input_buffer_override_value;
  } pgh_ovr_t;

endpackage : pgh_pkg

// >>> core/pgh_sync.sv
// Purpose: Two flip-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are levels; pulses shorter than a clock may be missed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module pgh_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Data.
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : pgh_sync
`default_nettype wire
